// File: hw/dmc_ctrl.sv
// dual-monitor control: monitor register, safer mode, activation checks
`timescale 1ns/1ps
module dmc_ctrl
  import dmc_pkg::*;
#(
  parameter int          PTR_W      = 64,
  parameter logic [31:0] SEG_REV_ID = DMC_SEG_REV_ID
) (
  input  wire logic             clk,
  input  wire logic             rst,
  // processor capabilities and mode
  input  wire logic             dual_supported,
  input  wire logic             cap_64bit,
  input  wire logic             in_64bit_mode,
  input  wire logic             in_mgmt_mode,
  input  wire logic             root_operation,
  input  wire logic             v86_mode,
  input  wire logic             compat_mode,
  input  wire logic [1:0]       privilege_level,
  // model register access
  input  wire logic             msr_req,
  input  wire logic             msr_wr,
  input  wire logic [31:0]      msr_addr,
  input  wire logic [63:0]      msr_wdata,
  input  wire logic             msr_in_exit,
  input  wire logic             msr_exit_ends_mgmt,
  input  wire logic             msr_in_entry,
  input  wire logic             msr_entry_begins_mgmt,
  output logic                  msr_ack_q,
  output logic [63:0]           msr_rdata_q,
  output logic                  msr_fault_q,
  output logic                  msr_fail_q,
  // security instruction leaves and virtualization-off
  input  wire logic             sec_enter,
  input  wire logic             sec_exit,
  input  wire logic             sec_clear_block,
  input  wire logic             voff_exec,
  input  wire logic             default_treatment,
  output logic                  safer_mode_q,
  output logic                  voff_unblock_q,
  // monitor call activation
  input  wire logic             mc_req,
  input  wire logic             cur_ptr_valid,
  input  wire logic             launch_clear,
  input  wire logic             exit_ctl_ok,
  output logic                  mem_req_q,
  output logic [31:0]           mem_addr_q,
  input  wire logic             mem_ack,
  input  wire logic [31:0]      mem_rdata,
  output logic                  mc_done_q,
  output logic                  mc_attempt_q,
  output dmc_fail_t             mc_fail_q,
  output logic                  mgmt_exit_q,
  output logic                  long_mode_q,
  output logic                  dual_active_q,
  // return entry from management mode
  input  wire logic             entry_req,
  input  wire logic             deact_ctl,
  input  wire logic [PTR_W-1:0] exec_ptr,
  input  wire logic [PTR_W-1:0] root_ptr,
  input  wire logic [PTR_W-1:0] link_ptr,
  input  wire logic [PTR_W-1:0] pre_ptr,
  input  wire logic [31:0]      intr_state,
  input  wire logic             entry_fail,
  input  wire logic             exec_induce,
  output logic                  entry_done_q,
  output logic                  non_root_q,
  output logic                  induced_exit_q,
  output logic                  exit_to_exec_q,
  output logic                  smi_blocked_q,
  output logic                  fail_recorded_q,
  output logic [PTR_W-1:0]      cur_ptr_q
);
  logic [63:0]           monctl_q;
  dmc_state_t            state_q;
  logic [DMC_BASE_W-1:0] base_q;
  logic [31:0]           feat_q;
  logic                  deact_done_q;
  logic                  hit;
  logic                  plain;
  logic                  xfail;
  logic                  rsvd_set;
  logic                  do_store;
  logic                  do_fault;
  logic                  do_fail;
  logic                  start_ok;
  logic                  feat_bad;

  // access decode
  assign hit      = msr_req && (msr_addr == DMC_MONCTL_ADDR);
  assign plain    = !msr_in_exit && !msr_in_entry;
  assign xfail    = (msr_in_exit && !msr_exit_ends_mgmt) ||
                    (msr_in_entry && !msr_entry_begins_mgmt);
  assign rsvd_set = |(msr_wdata & DMC_MONCTL_RSVD);

  always_comb begin
    do_store = 1'b0;
    do_fault = 1'b0;
    do_fail  = 1'b0;
    if (hit) begin
      if (!dual_supported) begin
        do_fault = plain;
        do_fail  = !plain;
      end else if (msr_wr) begin
        if (xfail) begin
          do_fail = 1'b1;
        end else if (plain && !in_mgmt_mode) begin
          do_fault = 1'b1;
        end else if (rsvd_set) begin
          do_fault = plain;
          do_fail  = !plain;
        end else begin
          do_store = 1'b1;
        end
      end
    end
  end

  // monitor control register
  always_ff @(posedge clk) begin
    if (rst) begin
      monctl_q <= DMC_MONCTL_RESET;
    end else if (do_store) begin
      monctl_q <= msr_wdata & ~DMC_MONCTL_RSVD;
    end else if (sec_clear_block) begin
      monctl_q[DMC_BLOCK_BIT] <= 1'b0;
    end
  end

  // register access answer
  always_ff @(posedge clk) begin
    if (rst) begin
      msr_ack_q   <= 1'b0;
      msr_rdata_q <= '0;
      msr_fault_q <= 1'b0;
      msr_fail_q  <= 1'b0;
    end else begin
      msr_ack_q   <= hit;
      msr_fault_q <= do_fault;
      msr_fail_q  <= do_fail;
      if (hit && !msr_wr && dual_supported) begin
        msr_rdata_q <= monctl_q;
      end
    end
  end

  // safer mode tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      safer_mode_q <= 1'b0;
    end else if (sec_enter) begin
      safer_mode_q <= 1'b1;
    end else if (sec_exit) begin
      safer_mode_q <= 1'b0;
    end
  end

  // virtualization-off under default handling
  always_ff @(posedge clk) begin
    if (rst) begin
      voff_unblock_q <= 1'b0;
    end else begin
      voff_unblock_q <= voff_exec && default_treatment && !monctl_q[DMC_BLOCK_BIT];
    end
  end

  // activation preconditions
  assign start_ok = dual_supported && root_operation && !in_mgmt_mode &&
                    monctl_q[DMC_VALID_BIT] && !v86_mode && !compat_mode &&
                    (privilege_level == DMC_PRIV_TOP) && !dual_active_q;

  assign feat_bad = |(mem_rdata & DMC_FEAT_RSVD) ||
                    (!cap_64bit && mem_rdata[DMC_FEAT_LONG]) ||
                    (in_64bit_mode && !mem_rdata[DMC_FEAT_LONG]);

  // activation check sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q      <= DMC_IDLE;
      base_q       <= '0;
      feat_q       <= '0;
      mem_req_q    <= 1'b0;
      mem_addr_q   <= '0;
      mc_done_q    <= 1'b0;
      mc_attempt_q <= 1'b0;
      mc_fail_q    <= DMC_F_NONE;
      mgmt_exit_q  <= 1'b0;
      long_mode_q  <= 1'b0;
    end else begin
      mc_done_q   <= 1'b0;
      mgmt_exit_q <= 1'b0;
      mem_req_q   <= 1'b0;
      case (state_q)
        DMC_IDLE: begin
          if (mc_req) begin
            mc_fail_q <= DMC_F_NONE;
            if (start_ok) begin
              state_q <= DMC_CHK_PTR;
            end else begin
              mc_done_q    <= 1'b1;
              mc_attempt_q <= 1'b0;
            end
          end
        end
        DMC_CHK_PTR: begin
          if (!cur_ptr_valid) begin
            mc_fail_q    <= DMC_F_NOPTR;
            mc_done_q    <= 1'b1;
            mc_attempt_q <= 1'b1;
            state_q      <= DMC_IDLE;
          end else begin
            state_q <= DMC_CHK_LAUNCH;
          end
        end
        DMC_CHK_LAUNCH: begin
          if (!launch_clear) begin
            mc_fail_q    <= DMC_F_LAUNCH;
            mc_done_q    <= 1'b1;
            mc_attempt_q <= 1'b1;
            state_q      <= DMC_IDLE;
          end else begin
            state_q <= DMC_CHK_EXITCTL;
          end
        end
        DMC_CHK_EXITCTL: begin
          if (!exit_ctl_ok) begin
            mc_fail_q    <= DMC_F_EXITCTL;
            mc_done_q    <= 1'b1;
            mc_attempt_q <= 1'b1;
            state_q      <= DMC_IDLE;
          end else begin
            base_q  <= monctl_q[DMC_BASE_MSB:DMC_BASE_LSB];
            state_q <= DMC_RD_REV;
          end
        end
        DMC_RD_REV: begin
          mem_req_q  <= 1'b1;
          mem_addr_q <= {base_q, DMC_BASE_PAD} + DMC_HDR_REV;
          state_q    <= DMC_WT_REV;
        end
        DMC_WT_REV: begin
          if (mem_ack) begin
            if (mem_rdata != SEG_REV_ID) begin
              mc_fail_q    <= DMC_F_REV;
              mc_done_q    <= 1'b1;
              mc_attempt_q <= 1'b1;
              state_q      <= DMC_IDLE;
            end else begin
              state_q <= DMC_RD_FEAT;
            end
          end
        end
        DMC_RD_FEAT: begin
          mem_req_q  <= 1'b1;
          mem_addr_q <= {base_q, DMC_BASE_PAD} + DMC_HDR_FEAT;
          state_q    <= DMC_WT_FEAT;
        end
        DMC_WT_FEAT: begin
          if (mem_ack) begin
            mc_done_q    <= 1'b1;
            mc_attempt_q <= 1'b1;
            state_q      <= DMC_IDLE;
            if (feat_bad) begin
              mc_fail_q <= DMC_F_FEAT;
            end else begin
              feat_q      <= mem_rdata;
              long_mode_q <= mem_rdata[DMC_FEAT_LONG];
              mgmt_exit_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= DMC_IDLE;
        end
      endcase
    end
  end

  // dual-monitor active flag
  always_ff @(posedge clk) begin
    if (rst) begin
      dual_active_q <= 1'b0;
    end else if (state_q == DMC_WT_FEAT && mem_ack && !feat_bad) begin
      dual_active_q <= 1'b1;
    end else if (deact_done_q) begin
      dual_active_q <= 1'b0;
    end
  end

  dmc_entry_eval #(
    .PTR_W (PTR_W)
  ) u_entry (
    .clk             (clk),
    .rst             (rst),
    .entry_req       (entry_req),
    .deact_ctl       (deact_ctl),
    .exec_ptr        (exec_ptr),
    .root_ptr        (root_ptr),
    .link_ptr        (link_ptr),
    .pre_ptr         (pre_ptr),
    .intr_state      (intr_state),
    .safer_mode      (safer_mode_q),
    .entry_fail      (entry_fail),
    .exec_induce     (exec_induce),
    .entry_done_q    (entry_done_q),
    .non_root_q      (non_root_q),
    .induced_exit_q  (induced_exit_q),
    .exit_to_exec_q  (exit_to_exec_q),
    .smi_blocked_q   (smi_blocked_q),
    .fail_recorded_q (fail_recorded_q),
    .deact_done_q    (deact_done_q),
    .cur_ptr_q       (cur_ptr_q)
  );

  AST_VALID_RESET: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> !monctl_q[DMC_VALID_BIT])
    else $error("valid flag set right after reset");
  AST_START_VALID: assert property (@(posedge clk) disable iff (rst)
    state_q == DMC_CHK_PTR && $past(state_q) == DMC_IDLE |-> $past(monctl_q[DMC_VALID_BIT]))
    else $error("activation began with valid flag clear");
  AST_START_COND: assert property (@(posedge clk) disable iff (rst)
    state_q == DMC_IDLE && mc_req && !start_ok |=> mc_done_q && !mc_attempt_q && state_q == DMC_IDLE)
    else $error("activation attempted without preconditions");
  AST_VOFF: assert property (@(posedge clk) disable iff (rst)
    voff_exec && default_treatment |=> voff_unblock_q == !$past(monctl_q[DMC_BLOCK_BIT]))
    else $error("virtualization-off unblock wrong");
  AST_RSVD_FAULT: assert property (@(posedge clk) disable iff (rst)
    hit && msr_wr && plain && dual_supported && in_mgmt_mode && rsvd_set && !sec_clear_block
    |=> msr_fault_q && $stable(monctl_q))
    else $error("reserved bit write not faulted");
  AST_UNSUP_FAULT: assert property (@(posedge clk) disable iff (rst)
    hit && plain && !dual_supported |=> msr_ack_q && msr_fault_q)
    else $error("access without support not faulted");
  AST_XFAIL: assert property (@(posedge clk) disable iff (rst)
    hit && msr_wr && xfail && !sec_clear_block |=> msr_fail_q && !msr_fault_q && $stable(monctl_q))
    else $error("transition write not failed");
  AST_SAFER: assert property (@(posedge clk) disable iff (rst)
    sec_enter |=> safer_mode_q)
    else $error("safer mode not entered");
  AST_SAFER_EXIT: assert property (@(posedge clk) disable iff (rst)
    sec_exit && !sec_enter |=> !safer_mode_q)
    else $error("safer mode not left");
  AST_CHECK_ORDER: assert property (@(posedge clk) disable iff (rst)
    state_q == DMC_CHK_PTR && !cur_ptr_valid |=> mc_fail_q == DMC_F_NOPTR && state_q == DMC_IDLE && !mem_req_q)
    else $error("pointer check did not stop sequence");
  AST_REV_ADDR: assert property (@(posedge clk) disable iff (rst)
    state_q == DMC_WT_REV && $past(state_q) == DMC_RD_REV |-> mem_req_q && mem_addr_q[DMC_BASE_MSB:DMC_BASE_LSB] == base_q)
    else $error("revision read not at segment base");
  AST_ACT_STATE: assert property (@(posedge clk) disable iff (rst)
    $rose(dual_active_q) |-> mgmt_exit_q && (feat_q & DMC_FEAT_RSVD) == 32'h00000000)
    else $error("activation without passing all checks");

  COV_ACTIVATE: cover property (@(posedge clk) disable iff (rst) mgmt_exit_q);
  COV_REV_FAIL: cover property (@(posedge clk) disable iff (rst) mc_done_q && mc_fail_q == DMC_F_REV);
  COV_WRITE_OK: cover property (@(posedge clk) disable iff (rst) do_store ##1 monctl_q[DMC_VALID_BIT]);
  COV_ENTRY_FAIL: cover property (@(posedge clk) disable iff (rst) fail_recorded_q);
endmodule

// File: hw/dmc_pkg.sv
// constants and types shared by the dual-monitor control logic
package dmc_pkg;
  localparam logic [31:0] DMC_MONCTL_ADDR  = 32'h0000009B;
  localparam logic [63:0] DMC_MONCTL_RESET = 64'h0000000000000000;
  localparam logic [63:0] DMC_MONCTL_RSVD  = 64'hFFFFFFFF00000FFA;
  localparam int          DMC_VALID_BIT    = 0;
  localparam int          DMC_BLOCK_BIT    = 2;
  localparam int          DMC_BASE_LSB     = 12;
  localparam int          DMC_BASE_MSB     = 31;
  localparam int          DMC_BASE_W       = DMC_BASE_MSB - DMC_BASE_LSB + 1;
  localparam logic [11:0] DMC_BASE_PAD     = 12'h000;
  // monitor segment header byte offsets
  localparam logic [31:0] DMC_HDR_REV      = 32'h00000000;
  localparam logic [31:0] DMC_HDR_FEAT     = 32'h00000004;
  localparam logic [31:0] DMC_HDR_GDT_LIM  = 32'h00000008;
  localparam logic [31:0] DMC_HDR_GDT_BASE = 32'h0000000C;
  localparam logic [31:0] DMC_HDR_CS_SEL   = 32'h00000010;
  localparam logic [31:0] DMC_HDR_IP_OFS   = 32'h00000014;
  localparam logic [31:0] DMC_HDR_SP_OFS   = 32'h00000018;
  localparam logic [31:0] DMC_HDR_PT_OFS   = 32'h0000001C;
  localparam int          DMC_HDR_BYTES    = 32;
  localparam int          DMC_FEAT_LONG    = 0;
  localparam logic [31:0] DMC_FEAT_RSVD    = 32'hFFFFFFFE;
  localparam int          DMC_INTR_SMI_BIT = 2;
  localparam logic [1:0]  DMC_PRIV_TOP     = 2'h0;
  // arbitrary neutral segment revision identifier
  localparam logic [31:0] DMC_SEG_REV_ID   = 32'h00000001;

  typedef enum logic [3:0] {
    DMC_IDLE, DMC_CHK_PTR, DMC_CHK_LAUNCH, DMC_CHK_EXITCTL,
    DMC_RD_REV, DMC_WT_REV, DMC_RD_FEAT, DMC_WT_FEAT
  } dmc_state_t;

  typedef enum logic [2:0] {
    DMC_F_NONE, DMC_F_NOPTR, DMC_F_LAUNCH, DMC_F_EXITCTL, DMC_F_REV, DMC_F_FEAT
  } dmc_fail_t;
endpackage

// File: hw/dmc_entry_eval.sv
// outcome of an entry that returns from management mode
`timescale 1ns/1ps
module dmc_entry_eval
  import dmc_pkg::*;
#(
  parameter int PTR_W = 64
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             entry_req,
  input  wire logic             deact_ctl,
  input  wire logic [PTR_W-1:0] exec_ptr,
  input  wire logic [PTR_W-1:0] root_ptr,
  input  wire logic [PTR_W-1:0] link_ptr,
  input  wire logic [PTR_W-1:0] pre_ptr,
  input  wire logic [31:0]      intr_state,
  input  wire logic             safer_mode,
  input  wire logic             entry_fail,
  input  wire logic             exec_induce,
  output logic                  entry_done_q,
  output logic                  non_root_q,
  output logic                  induced_exit_q,
  output logic                  exit_to_exec_q,
  output logic                  smi_blocked_q,
  output logic                  fail_recorded_q,
  output logic                  deact_done_q,
  output logic [PTR_W-1:0]      cur_ptr_q
);
  logic non_root;
  assign non_root = (exec_ptr != root_ptr);

  always_ff @(posedge clk) begin
    if (rst) begin
      entry_done_q    <= 1'b0;
      non_root_q      <= 1'b0;
      induced_exit_q  <= 1'b0;
      exit_to_exec_q  <= 1'b0;
      fail_recorded_q <= 1'b0;
      deact_done_q    <= 1'b0;
      cur_ptr_q       <= '0;
    end else begin
      entry_done_q    <= entry_req;
      deact_done_q    <= entry_req && deact_ctl && !entry_fail;
      induced_exit_q  <= entry_req && !entry_fail && non_root && exec_induce;
      exit_to_exec_q  <= entry_req && !entry_fail && non_root && exec_induce;
      fail_recorded_q <= entry_req && entry_fail;
      if (entry_req) begin
        non_root_q <= non_root && !entry_fail;
        if (entry_fail) begin
          cur_ptr_q <= pre_ptr;
        end else begin
          cur_ptr_q <= non_root ? exec_ptr : link_ptr;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      smi_blocked_q <= 1'b0;
    end else if (entry_req && !entry_fail) begin
      if (deact_ctl) begin
        smi_blocked_q <= safer_mode;
      end else begin
        smi_blocked_q <= intr_state[DMC_INTR_SMI_BIT];
      end
    end
  end

  AST_SMI_BIT: assert property (@(posedge clk) disable iff (rst)
    entry_req && !entry_fail && !deact_ctl |=> smi_blocked_q == $past(intr_state[DMC_INTR_SMI_BIT]))
    else $error("block state does not follow interruptibility bit");
  AST_SMI_SAFER: assert property (@(posedge clk) disable iff (rst)
    entry_req && !entry_fail && deact_ctl |=> smi_blocked_q == $past(safer_mode))
    else $error("block state does not follow safer mode");
  AST_NO_INDUCED_ROOT: assert property (@(posedge clk) disable iff (rst)
    entry_req && exec_ptr == root_ptr |=> !induced_exit_q)
    else $error("induced exit while staying in root operation");
  AST_FAIL_PTR: assert property (@(posedge clk) disable iff (rst)
    entry_req && entry_fail |=> fail_recorded_q && cur_ptr_q == $past(pre_ptr))
    else $error("failed entry left wrong structure current");
endmodule

// File: tb/test_dmc_ctrl.sv
// self-checking bench for the dual-monitor control block
`timescale 1ns/1ps
module test_dmc_ctrl;
  import dmc_pkg::*;
  logic clk, rst, dual_supported, cap_64bit, in_64bit_mode, in_mgmt_mode, root_operation, v86_mode, compat_mode;
  logic msr_req, msr_wr, msr_in_exit, msr_exit_ends_mgmt, msr_in_entry, msr_entry_begins_mgmt, msr_ack_q;
  logic msr_fault_q, msr_fail_q, sec_enter, sec_exit, sec_clear_block, voff_exec, default_treatment;
  logic safer_mode_q, voff_unblock_q, mc_req, cur_ptr_valid, launch_clear, exit_ctl_ok, mem_req_q, mem_ack;
  logic mc_done_q, mc_attempt_q, mgmt_exit_q, long_mode_q, dual_active_q, entry_req, deact_ctl, entry_fail;
  logic exec_induce, entry_done_q, non_root_q, induced_exit_q, exit_to_exec_q, smi_blocked_q, fail_recorded_q;
  logic [1:0]  privilege_level;
  logic [31:0] msr_addr, mem_addr_q, mem_rdata, intr_state;
  logic [63:0] msr_wdata, msr_rdata_q, exec_ptr, root_ptr, link_ptr, pre_ptr, cur_ptr_q;
  dmc_fail_t   mc_fail_q;
  int          fails, n_compared, cyc;
  dmc_ctrl dmc_ctrl_i (.*);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic msr(input logic wr, input logic [63:0] d, input logic [3:0] q, input logic flt, input logic fl);
    {msr_wr, msr_wdata} = {wr, d};
    {msr_in_exit, msr_exit_ends_mgmt, msr_in_entry, msr_entry_begins_mgmt} = q;
    pulse(msr_req);
    chk("msr_ack_q", 64'h1, 64'(msr_ack_q));
    chk("msr_fault_q", 64'(flt), 64'(msr_fault_q));
    chk("msr_fail_q", 64'(fl), 64'(msr_fail_q));
    @(negedge clk);
  endtask
  task automatic t_reg;
    msr(1'b0, 64'h0, 4'h0, 1'b0, 1'b0);
    chk("reset value", DMC_MONCTL_RESET, msr_rdata_q);
    in_mgmt_mode = 1'b1;
    msr(1'b1, 64'h5005, 4'h0, 1'b0, 1'b0);
    msr(1'b1, 64'h2, 4'h0, 1'b1, 1'b0);
    msr(1'b1, 64'h8, 4'h0, 1'b1, 1'b0);
    msr(1'b1, 64'h100000000, 4'h0, 1'b1, 1'b0);
    msr(1'b1, 64'h0, 4'h8, 1'b0, 1'b1);
    msr(1'b1, 64'h0, 4'h2, 1'b0, 1'b1);
    in_mgmt_mode = 1'b0;
    msr(1'b1, 64'h0, 4'h0, 1'b1, 1'b0);
    msr(1'b0, 64'h0, 4'h8, 1'b0, 1'b0);
    chk("monitor_control", 64'h5005, msr_rdata_q);
    dual_supported = 1'b0;
    msr(1'b0, 64'h0, 4'h0, 1'b1, 1'b0);
    msr(1'b1, 64'h0, 4'h8, 1'b0, 1'b1);
    dual_supported = 1'b1;
    msr_addr = 32'h0000009C;
    pulse(msr_req);
    chk("unmapped ack", 64'h0, 64'(msr_ack_q));
    msr_addr = DMC_MONCTL_ADDR;
  endtask
  task automatic t_voff;
    pulse(voff_exec);
    chk("voff_unblock_q", 64'h0, 64'(voff_unblock_q));
    pulse(sec_clear_block);
    pulse(voff_exec);
    chk("voff_unblock_q", 64'h1, 64'(voff_unblock_q));
    msr(1'b0, 64'h0, 4'h0, 1'b0, 1'b0);
    chk("monitor_control", 64'h5001, msr_rdata_q);
    default_treatment = 1'b0;
    pulse(voff_exec);
    chk("voff_unblock_q", 64'h0, 64'(voff_unblock_q));
    default_treatment = 1'b1;
  endtask
  task automatic mcall(input logic [31:0] rev, input logic [31:0] feat, input dmc_fail_t f, input logic att);
    int n;
    int k;
    k = 0;
    pulse(mc_req);
    for (n = 0; n < 40 && mc_done_q !== 1'b1; n++) begin
      if (mem_req_q === 1'b1) begin
        chk("mem_addr_q", 64'(32'h5000 + (k > 0 ? DMC_HDR_FEAT : DMC_HDR_REV)), 64'(mem_addr_q));
        mem_rdata = k > 0 ? feat : rev;
        mem_ack = 1'b1;
        k++;
      end
      @(negedge clk);
      mem_ack = 1'b0;
    end
    chk("mc_done_q", 64'h1, 64'(mc_done_q));
    chk("mc_attempt_q", 64'(att), 64'(mc_attempt_q));
    chk("mc_fail_q", 64'(f), 64'(mc_fail_q));
    chk("mgmt_exit_q", 64'(att && f == DMC_F_NONE), 64'(mgmt_exit_q));
    @(negedge clk);
  endtask
  task automatic t_mc;
    in_mgmt_mode = 1'b1;
    msr(1'b1, 64'h5000, 4'h0, 1'b0, 1'b0);
    in_mgmt_mode = 1'b0;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    in_mgmt_mode = 1'b1;
    msr(1'b1, 64'h5001, 4'h0, 1'b0, 1'b0);
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    {in_mgmt_mode, v86_mode} = 2'h1;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    {v86_mode, compat_mode} = 2'h1;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    {compat_mode, root_operation} = 2'h0;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    {root_operation, privilege_level} = 3'h7;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    {dual_supported, privilege_level} = 3'h0;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
    dual_supported = 1'b1;
    {cur_ptr_valid, launch_clear, exit_ctl_ok} = 3'h0;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NOPTR, 1'b1);
    cur_ptr_valid = 1'b1;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_LAUNCH, 1'b1);
    launch_clear = 1'b1;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_EXITCTL, 1'b1);
    exit_ctl_ok = 1'b1;
    mcall(32'h2, 32'h1, DMC_F_REV, 1'b1);
    mcall(DMC_SEG_REV_ID, 32'h3, DMC_F_FEAT, 1'b1);
    mcall(DMC_SEG_REV_ID, 32'h0, DMC_F_FEAT, 1'b1);
    {cap_64bit, in_64bit_mode} = 2'h0;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_FEAT, 1'b1);
    chk("dual_active_q", 64'h0, 64'(dual_active_q));
    {cap_64bit, in_64bit_mode} = 2'h3;
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b1);
    chk("long_mode_q", 64'h1, 64'(long_mode_q));
    chk("dual_active_q", 64'h1, 64'(dual_active_q));
    mcall(DMC_SEG_REV_ID, 32'h1, DMC_F_NONE, 1'b0);
  endtask
  task automatic ent(input logic [63:0] ex, input logic [1:0] dcf, input logic [31:0] is, input logic blk,
                     input logic nr, input logic [63:0] ptr);
    {exec_ptr, deact_ctl, entry_fail, intr_state} = {ex, dcf, is};
    pulse(entry_req);
    chk("entry_done_q", 64'h1, 64'(entry_done_q));
    chk("smi_blocked_q", 64'(blk), 64'(smi_blocked_q));
    chk("non_root_q", 64'(nr && !dcf[0]), 64'(non_root_q));
    chk("induced_exit_q", 64'(nr && !dcf[0] && exec_induce), 64'(induced_exit_q));
    chk("exit_to_exec_q", 64'(nr && !dcf[0] && exec_induce), 64'(exit_to_exec_q));
    chk("cur_ptr_q", ptr, cur_ptr_q);
    chk("fail_recorded_q", 64'(dcf[0]), 64'(fail_recorded_q));
    @(negedge clk);
  endtask
  task automatic t_entry;
    ent(64'h3000, 2'h0, 32'h4, 1'b1, 1'b1, 64'h3000);
    exec_induce = 1'b0;
    ent(64'h3000, 2'h0, 32'h0, 1'b0, 1'b1, 64'h3000);
    exec_induce = 1'b1;
    ent(64'h1000, 2'h0, 32'h0, 1'b0, 1'b0, 64'h2000);
    ent(64'h3000, 2'h1, 32'h4, 1'b0, 1'b1, 64'h4000);
    pulse(sec_enter);
    chk("safer_mode_q", 64'h1, 64'(safer_mode_q));
    ent(64'h1000, 2'h2, 32'h0, 1'b1, 1'b0, 64'h2000);
    chk("dual_active_q", 64'h0, 64'(dual_active_q));
    pulse(sec_exit);
    chk("safer_mode_q", 64'h0, 64'(safer_mode_q));
    ent(64'h1000, 2'h2, 32'h4, 1'b0, 1'b0, 64'h2000);
  endtask
  task automatic t_rst;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("long_mode_q", 64'h0, 64'(long_mode_q));
    msr(1'b0, 64'h0, 4'h0, 1'b0, 1'b0);
    chk("monitor_control", DMC_MONCTL_RESET, msr_rdata_q);
  endtask
  initial begin
    {dual_supported, cap_64bit, in_64bit_mode, root_operation, default_treatment} = 5'h1F;
    {in_mgmt_mode, v86_mode, compat_mode, msr_req, msr_wr, msr_in_exit, msr_exit_ends_mgmt, msr_in_entry} = 8'h00;
    {msr_entry_begins_mgmt, sec_enter, sec_exit, sec_clear_block, voff_exec, mc_req, mem_ack, entry_req} = 8'h00;
    {cur_ptr_valid, launch_clear, exit_ctl_ok, exec_induce, deact_ctl, entry_fail} = 6'h3C;
    {privilege_level, msr_addr, mem_rdata, intr_state} = {2'h0, DMC_MONCTL_ADDR, 64'h0};
    {msr_wdata, root_ptr, link_ptr, pre_ptr, exec_ptr} = {64'h0, 64'h1000, 64'h2000, 64'h4000, 64'h3000};
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reg();
    t_voff();
    t_mc();
    t_entry();
    t_rst();
    wrap_up();
  end
endmodule
